// ### bench/tcr_cpu_model.sv
`timescale 1ns/1ps
module tcr_cpu_model
	import tcr_pkg::*;
(
	// clock
	input  wire logic       clk,
	// byte bus toward the timer
	output logic      [7:0] cpu_addr,
	output logic      [7:0] cpu_wdata,
	output logic            cpu_wr,
	output logic            cpu_rd,
	input  wire logic [7:0] cpu_rdata
);
	// idle bus from time zero
	initial begin
		cpu_addr = BYTE_RST;
		cpu_wdata = BYTE_RST;
		cpu_wr = 1'b0;
		cpu_rd = 1'b0;
	end
	// one byte write, strobe held for one edge
	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr = 1'b1;
		@(posedge clk) #1;
		cpu_wr = 1'b0;
	endtask
	// one byte read, data taken the cycle after the strobe
	task automatic rd8(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk) #1;
		cpu_addr = a;
		cpu_rd = 1'b1;
		@(posedge clk) #1;
		cpu_rd = 1'b0;
		d = cpu_rdata;
	endtask
	// word write: high byte into the latch first
	task automatic wr16(input logic [7:0] a, input logic [15:0] d);
		wr8(a + HI_OFS, d[15:8]);
		wr8(a, d[7:0]);
	endtask
	// word read: low byte first latches the high byte
	task automatic rd16(input logic [7:0] a, output logic [15:0] d);
		rd8(a, d[7:0]);
		rd8(a + HI_OFS, d[15:8]);
	endtask
endmodule

// ### bench/tcr_timer16_assertions.sv
`timescale 1ns/1ps
module tcr_timer16_checker
	import tcr_pkg::*;
(
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_b,
	// cpu byte bus
	input wire logic [7:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic       cpu_wr,
	input wire logic       cpu_rd,
	input wire logic [7:0] cpu_rdata,
	// configuration
	input wire logic [2:0] clock_select_field,
	input wire logic [3:0] waveform_mode_field,
	input wire logic [1:0] output_mode_field_a,
	input wire logic [1:0] output_mode_field_b,
	// outputs
	input wire logic       waveform_out_a,
	input wire logic       waveform_out_b,
	input wire logic       capture_flag,
	input wire logic       compare_flag_a,
	input wire logic       compare_flag_b
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// non-pwm modes where force strobes act
	wire npwm = waveform_mode_field inside {WGM_NORMAL, WGM_CTC_A, WGM_CTC_CAP};
	// counter without a source for four cycles
	sequence stop_s;
		(clock_select_field == CS_STOP)[*4];
	endsequence
	// force strobes while stopped
	sequence frc_a_s;
		stop_s ##0 (cpu_wr && cpu_addr == ADDR_FORCE && cpu_wdata[FORCE_A_BIT]);
	endsequence
	sequence frc_b_s;
		stop_s ##0 (cpu_wr && cpu_addr == ADDR_FORCE && cpu_wdata[FORCE_B_BIT]);
	endsequence
	AST_IDLE_RDATA: assert property (!cpu_rd |=> cpu_rdata == BYTE_RST)
		else $error("read data not idle");
	AST_FORCE_READ_ZERO: assert property (cpu_rd && cpu_addr == ADDR_FORCE |=> cpu_rdata == BYTE_RST)
		else $error("force register read not zero");
	AST_FORCE_A_SET: assert property (frc_a_s ##0 (npwm && output_mode_field_a == COM_SET) |=> waveform_out_a)
		else $error("forced set missing");
	AST_FORCE_B_CLEAR: assert property (frc_b_s ##0 (npwm && output_mode_field_b == COM_CLEAR) |=> !waveform_out_b)
		else $error("forced clear missing");
	AST_FORCE_TOGGLE: assert property (frc_a_s ##0 (npwm && output_mode_field_a == COM_TOGGLE) |=> $changed(waveform_out_a))
		else $error("forced toggle missing");
	AST_FORCE_PWM_NOP: assert property (frc_a_s ##0 !npwm |=> $stable(waveform_out_a))
		else $error("force acted in pwm mode");
	AST_FORCE_NO_FLAG: assert property (frc_a_s or frc_b_s |=> !compare_flag_a && !compare_flag_b)
		else $error("forced match raised a flag");
	AST_STOP_NO_MATCH: assert property (stop_s |-> !compare_flag_a && !compare_flag_b)
		else $error("match while stopped");
	AST_MATCH_TOGGLE: assert property (compare_flag_a && output_mode_field_a == COM_TOGGLE |-> $changed(waveform_out_a))
		else $error("match did not toggle output");
	AST_CAP_PULSE: assert property (capture_flag |=> !capture_flag)
		else $error("capture flag longer than one cycle");
endmodule
bind tcr_timer16 tcr_timer16_checker tcr_timer16_checker_i (.clk, .rst_b, .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_rd,
	.cpu_rdata, .clock_select_field, .waveform_mode_field, .output_mode_field_a, .output_mode_field_b,
	.waveform_out_a, .waveform_out_b, .capture_flag, .compare_flag_a, .compare_flag_b);

// ### bench/tcr_timer16_tb.sv
`timescale 1ns/1ps
module tcr_timer16_tb
	import tcr_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  cpu_addr, cpu_wdata, cpu_rdata, b;
	logic        cpu_wr, cpu_rd, out_a, out_b, fl_a, fl_b, fl_c, fa, fb, fc;
	logic [2:0]  cs = CS_STOP;
	logic [3:0]  wgm = WGM_NORMAL;
	logic [1:0]  com_a = COM_SET;
	logic [1:0]  com_b = COM_CLEAR;
	logic        ices = 1'b1;
	logic        icnc = 1'b0;
	logic        csrc = 1'b0;
	logic        ext = 1'b0;
	logic        icp = 1'b0;
	logic        acmp = 1'b0;
	logic [15:0] v;
	int          num_errors = 0;
	int          comparisons = 0;
	logic [7:0]  adr [4] = '{ADDR_CNT, ADDR_CAP, ADDR_CMPA, ADDR_CMPB};
	logic [2:0]  cst [5] = '{CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
	int          dvt [5] = '{1, 8, 64, 256, 1024};
	// 40 MHz clock
	always #12.5 clk = ~clk;
	// software side and the timer
	tcr_cpu_model tcr_cpu_model_i (.clk, .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_rd, .cpu_rdata);
	tcr_timer16 tcr_timer16_i (.clk, .rst_b, .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_rd, .cpu_rdata,
		.clock_select_field(cs), .waveform_mode_field(wgm), .output_mode_field_a(com_a),
		.output_mode_field_b(com_b), .capture_edge_select(ices), .capture_noise_filter_en(icnc),
		.capture_from_comparator(csrc), .external_count_pin(ext), .capture_input_pin(icp),
		.analog_comp_out(acmp), .waveform_out_a(out_a), .waveform_out_b(out_b), .capture_flag(fl_c),
		.compare_flag_a(fl_a), .compare_flag_b(fl_b));
	// compare and count
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// wait n edges, then step off the edge
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// gather event pulses over n cycles
	task automatic see(input int n);
		fa = fl_a;
		fb = fl_b;
		fc = fl_c;
		repeat (n) begin
			@(posedge clk) #1;
			fa = fa | fl_a;
			fb = fb | fl_b;
			fc = fc | fl_c;
		end
	endtask
	// counts and verdict
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// hang guard, about three times the expected run
	initial begin
		#1000000;
		num_errors++;
		$display("unexpected timeout: expected end seen hang");
		end_of_test();
	end
	// main sequence
	initial begin
		tk(5);
		rst_b = 1'b1;
		foreach (adr[i]) begin
			tcr_cpu_model_i.rd16(adr[i], v);
			chk("word reset", WORD_RST, v);
			tcr_cpu_model_i.wr16(adr[i], {adr[i], ~adr[i]});
			tcr_cpu_model_i.rd16(adr[i], v);
			chk("word readback", {adr[i], ~adr[i]}, v);
		end
		tcr_cpu_model_i.wr8(ADDR_CMPA + HI_OFS, 8'h77);
		tcr_cpu_model_i.wr8(ADDR_CMPB, 8'h11);
		tcr_cpu_model_i.rd16(ADDR_CMPB, v);
		chk("shared latch", 16'h7711, v);
		tcr_cpu_model_i.rd8(8'hb0, b);
		chk("unmapped read", 16'(BYTE_RST), 16'(b));
		$display("done: register access");
		tcr_cpu_model_i.wr8(ADDR_FORCE, 8'hc0);
		see(3);
		chk("force outputs", 16'h0040, {out_a, 3'h0, out_b, fa, fb});
		com_a = COM_TOGGLE;
		com_b = COM_TOGGLE;
		tcr_cpu_model_i.wr8(ADDR_FORCE, 8'h40);
		see(3);
		chk("force b only", 16'h0011, {out_a, 3'h0, out_b});
		wgm = WGM_FAST8;
		tcr_cpu_model_i.wr8(ADDR_FORCE, 8'hc0);
		tcr_cpu_model_i.rd8(ADDR_FORCE, b);
		chk("force read", 16'(BYTE_RST), 16'(b));
		chk("pwm force", 16'h0011, {out_a, 3'h0, out_b});
		wgm = WGM_CTC_A;
		tcr_cpu_model_i.wr8(ADDR_FORCE, 8'hc0);
		see(3);
		chk("ctc force", 16'h0000, {out_a, 3'h0, out_b, fa, fb});
		tcr_cpu_model_i.rd16(ADDR_CNT, v);
		chk("counter after force", {ADDR_CNT, ~ADDR_CNT}, v);
		$display("done: force strobes");
		wgm = WGM_NORMAL;
		tcr_cpu_model_i.wr16(ADDR_CMPA, 16'h0041);
		tcr_cpu_model_i.wr16(ADDR_CMPB, 16'h0040);
		tcr_cpu_model_i.wr16(ADDR_CNT, 16'h0040);
		cs = CS_DIV1;
		see(20);
		cs = CS_STOP;
		chk("match after write", 16'h0101, {fa, 3'h0, fb, 3'h0, out_a});
		$display("done: compare and write block");
		foreach (cst[i]) begin
			tcr_cpu_model_i.wr16(ADDR_CNT, WORD_RST);
			tk(4);
			cs = cst[i];
			tk(10 * dvt[i]);
			cs = CS_STOP;
			tcr_cpu_model_i.rd16(ADDR_CNT, v);
			chk("prescaled count", 16'h0001, 16'(v >= 9 && v <= 11));
		end
		for (int k = 0; k < 2; k++) begin
			tcr_cpu_model_i.wr16(ADDR_CNT, WORD_RST);
			cs = k ? CS_EXT_FALL : CS_EXT_RISE;
			repeat (10) begin
				tk(4);
				ext = ~ext;
			end
			tk(4);
			cs = CS_STOP;
			tcr_cpu_model_i.rd16(ADDR_CNT, v);
			chk("pin edge count", 16'h0005, v);
		end
		$display("done: clock sources");
		tcr_cpu_model_i.wr16(ADDR_CNT, 16'h1234);
		icp = 1'b1;
		see(12);
		tcr_cpu_model_i.rd16(ADDR_CAP, v);
		chk("rise capture", 16'h1235, {v[15:1], fc});
		ices = 1'b0;
		icnc = 1'b1;
		tcr_cpu_model_i.wr16(ADDR_CNT, 16'h4320);
		icp = 1'b0;
		see(16);
		tcr_cpu_model_i.rd16(ADDR_CAP, v);
		chk("filtered fall capture", 16'h4321, {v[15:1], fc});
		icp = 1'b1;
		see(16);
		chk("wrong edge", 16'h0000, 16'(fc));
		icp = 1'b0;
		tk(2);
		icp = 1'b1;
		see(16);
		chk("short glitch", 16'h0000, 16'(fc));
		ices = 1'b1;
		csrc = 1'b1;
		tk(8);
		acmp = 1'b1;
		see(16);
		chk("comparator capture", 16'h0001, 16'(fc));
		csrc = 1'b0;
		tcr_cpu_model_i.wr16(ADDR_CAP, 16'h0005);
		wgm = WGM_CTC_CAP;
		ices = 1'b0;
		icp = 1'b0;
		see(16);
		chk("capture in capture-top", 16'h0000, 16'(fc));
		tcr_cpu_model_i.wr16(ADDR_CNT, WORD_RST);
		cs = CS_DIV1;
		tk(40);
		tcr_cpu_model_i.rd16(ADDR_CNT, v);
		cs = CS_STOP;
		chk("capture as top", 16'h0001, 16'(v <= 16'h0005));
		$display("done: capture");
		end_of_test();
	end
endmodule

// ### design/tcr_cap_in.sv
`timescale 1ns/1ps
module tcr_cap_in
	import tcr_pkg::*;
#(
	parameter int FILT_LEN = FILTER_SAMPLES
)
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// capture source and options
	input  wire logic cap_src,
	input  wire logic capture_noise_filter_en,
	input  wire logic capture_edge_select,
	input  wire logic capture_enable,
	// capture event out
	tcr_evt_if.src_cap evt
);
	if (FILT_LEN < 2) begin : g_chk
		$error("filter length must be at least 2");
	end

	logic [FILT_LEN-1:0] samp;
	logic [FILT_LEN-1:0] next_samp;
	logic                lvl;
	logic                next_lvl;
	logic                lvl_prev;

	// with the filter enabled, the level changes only on a full run of equal samples; without it, it follows samp[0]
	always_comb begin
		next_samp = {samp[FILT_LEN-2:0], cap_src};
		next_lvl  = samp[0];
		if (capture_noise_filter_en) begin
			if (&samp)
				next_lvl = 1'b1;
			else if (~|samp)
				next_lvl = 1'b0;
			else
				next_lvl = lvl;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			samp     <= '0;
			lvl      <= 1'b0;
			lvl_prev <= 1'b0;
		end else begin
			samp     <= next_samp;
			lvl      <= next_lvl;
			lvl_prev <= lvl;
		end
	end

	// edge chosen by edge select, gated off when capture is disabled
	assign evt.cap_evt = capture_enable &
		(capture_edge_select ? (lvl & ~lvl_prev) : (~lvl & lvl_prev));
endmodule

// ### design/tcr_clock_sel.sv
`timescale 1ns/1ps
module tcr_clock_sel
	import tcr_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// source selection and pin
	input  wire logic [2:0] clock_select_field,
	input  wire logic       external_count_pin,
	// tick out
	tcr_evt_if.src_tick     evt
);
	logic [9:0] pre_cnt;
	logic [9:0] next_pre_cnt;
	logic [2:0] ext_sync;
	logic [2:0] next_ext_sync;
	logic       ext_rise;
	logic       ext_fall;

	// prescaler runs only while a source is selected
	always_comb begin
		next_pre_cnt  = (clock_select_field == CS_STOP) ? 10'h000 : 10'(pre_cnt + 10'h001);
		next_ext_sync = {ext_sync[1:0], external_count_pin};
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pre_cnt  <= 10'h000;
			ext_sync <= 3'h0;
		end else begin
			pre_cnt  <= next_pre_cnt;
			ext_sync <= next_ext_sync;
		end
	end

	// edges seen only after the two-stage synchroniser
	assign ext_rise = ext_sync[1] & ~ext_sync[2];
	assign ext_fall = ~ext_sync[1] & ext_sync[2];

	// one-cycle count enable per selected source
	always_comb begin
		case (clock_select_field)
			CS_STOP:     evt.tick = 1'b0;
			CS_DIV1:     evt.tick = 1'b1;
			CS_DIV8:     evt.tick = (pre_cnt & PRE_M8) == PRE_M8;
			CS_DIV64:    evt.tick = (pre_cnt & PRE_M64) == PRE_M64;
			CS_DIV256:   evt.tick = (pre_cnt & PRE_M256) == PRE_M256;
			CS_DIV1024:  evt.tick = (pre_cnt & PRE_M1024) == PRE_M1024;
			CS_EXT_FALL: evt.tick = ext_fall;
			CS_EXT_RISE: evt.tick = ext_rise;
			default:     evt.tick = 1'b0;
		endcase
	end
endmodule

// ### design/tcr_evt_if.sv
`timescale 1ns/1ps
interface tcr_evt_if;
	logic tick;
	logic cap_evt;
	modport src_tick (output tick);
	modport src_cap  (output cap_evt);
	modport sink     (input tick, input cap_evt);
endinterface

// ### design/tcr_pkg.sv
package tcr_pkg;
	// byte offsets of the register window
	localparam logic [7:0] ADDR_FORCE = 8'ha2;
	localparam logic [7:0] ADDR_CNT   = 8'ha4;
	localparam logic [7:0] ADDR_CAP   = 8'ha6;
	localparam logic [7:0] ADDR_CMPA  = 8'ha8;
	localparam logic [7:0] ADDR_CMPB  = 8'haa;
	localparam logic [7:0] HI_OFS     = 8'h01;
	// force register bit positions
	localparam int FORCE_A_BIT = 7;
	localparam int FORCE_B_BIT = 6;
	// reset values
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [7:0]  BYTE_RST = 8'h00;
	// clock select codes
	localparam logic [2:0] CS_STOP     = 3'h0;
	localparam logic [2:0] CS_DIV1     = 3'h1;
	localparam logic [2:0] CS_DIV8     = 3'h2;
	localparam logic [2:0] CS_DIV64    = 3'h3;
	localparam logic [2:0] CS_DIV256   = 3'h4;
	localparam logic [2:0] CS_DIV1024  = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	// prescaler tap masks
	localparam logic [9:0] PRE_M8    = 10'h007;
	localparam logic [9:0] PRE_M64   = 10'h03f;
	localparam logic [9:0] PRE_M256  = 10'h0ff;
	localparam logic [9:0] PRE_M1024 = 10'h3ff;
	// waveform modes that matter here
	localparam logic [3:0] WGM_NORMAL  = 4'h0;
	localparam logic [3:0] WGM_PC8     = 4'h1;
	localparam logic [3:0] WGM_PC9     = 4'h2;
	localparam logic [3:0] WGM_PC10    = 4'h3;
	localparam logic [3:0] WGM_CTC_A   = 4'h4;
	localparam logic [3:0] WGM_FAST8   = 4'h5;
	localparam logic [3:0] WGM_FAST9   = 4'h6;
	localparam logic [3:0] WGM_FAST10  = 4'h7;
	localparam logic [3:0] WGM_PFC_CAP = 4'h8;
	localparam logic [3:0] WGM_PFC_A   = 4'h9;
	localparam logic [3:0] WGM_PC_CAP  = 4'ha;
	localparam logic [3:0] WGM_PC_A    = 4'hb;
	localparam logic [3:0] WGM_CTC_CAP = 4'hc;
	localparam logic [3:0] WGM_FAST_CAP = 4'he;
	localparam logic [3:0] WGM_FAST_A  = 4'hf;
	// fixed top values
	localparam logic [15:0] TOP_8  = 16'h00ff;
	localparam logic [15:0] TOP_9  = 16'h01ff;
	localparam logic [15:0] TOP_10 = 16'h03ff;
	localparam logic [15:0] TOP_16 = 16'hffff;
	// output mode field codes
	localparam logic [1:0] COM_OFF    = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR  = 2'h2;
	localparam logic [1:0] COM_SET    = 2'h3;
	// capture noise filter depth
	localparam int FILTER_SAMPLES = 4;
	typedef logic [15:0] tcr_word_t;
endpackage

// ### design/tcr_timer16.sv
`timescale 1ns/1ps
module tcr_timer16
	import tcr_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// cpu byte bus
	input  wire logic [7:0] cpu_addr,
	input  wire logic [7:0] cpu_wdata,
	input  wire logic       cpu_wr,
	input  wire logic       cpu_rd,
	output logic      [7:0] cpu_rdata,
	// configuration fields
	input  wire logic [2:0] clock_select_field,
	input  wire logic [3:0] waveform_mode_field,
	input  wire logic [1:0] output_mode_field_a,
	input  wire logic [1:0] output_mode_field_b,
	input  wire logic       capture_edge_select,
	input  wire logic       capture_noise_filter_en,
	input  wire logic       capture_from_comparator,
	// pins
	input  wire logic       external_count_pin,
	input  wire logic       capture_input_pin,
	input  wire logic       analog_comp_out,
	output logic            waveform_out_a,
	output logic            waveform_out_b,
	// event pulses
	output logic            capture_flag,
	output logic            compare_flag_a,
	output logic            compare_flag_b
);
	tcr_evt_if evt ();

	tcr_word_t  counter_value;
	tcr_word_t  next_counter_value;
	tcr_word_t  capture_value;
	tcr_word_t  next_capture_value;
	tcr_word_t  cmp_val [2];
	tcr_word_t  next_cmp_val [2];
	logic [7:0] temp_hi;
	logic [7:0] next_temp_hi;
	logic [7:0] next_rdata;
	logic       block_match;
	logic       next_block_match;
	logic [1:0] wave;
	logic [1:0] next_wave;
	logic [1:0] match;
	logic [1:0] forced;
	logic [1:0] out_mode [2];
	logic       next_cap_flag;
	tcr_word_t  top_value;
	logic       cap_is_top;
	logic       non_pwm;
	logic       wr_force;
	logic [15:0] wr_word;
	logic       wr_cnt;
	logic       wr_cap;
	logic       wr_cmp [2];
	logic       wr_hi;
	logic [1:0] hit;
	logic       cap_src;
	logic       at_top;
	logic       next_cmp_flag_a;
	logic       next_cmp_flag_b;

	// clock source and capture input conditioning
	tcr_clock_sel u_clk (
		.clk                (clk),
		.rst_b              (rst_b),
		.clock_select_field (clock_select_field),
		.external_count_pin (external_count_pin),
		.evt                (evt.src_tick)
	);

	tcr_cap_in #(.FILT_LEN(FILTER_SAMPLES)) u_cap (
		.clk                     (clk),
		.rst_b                   (rst_b),
		.cap_src                 (cap_src),
		.capture_noise_filter_en (capture_noise_filter_en),
		.capture_edge_select     (capture_edge_select),
		.capture_enable          (~cap_is_top),
		.evt                     (evt.src_cap)
	);

	// top value decode per waveform mode
	always_comb begin
		cap_is_top = 1'b0;
		case (waveform_mode_field)
			WGM_PC8, WGM_FAST8:    top_value = TOP_8;
			WGM_PC9, WGM_FAST9:    top_value = TOP_9;
			WGM_PC10, WGM_FAST10:  top_value = TOP_10;
			WGM_CTC_A, WGM_PFC_A, WGM_PC_A, WGM_FAST_A: top_value = cmp_val[0];
			WGM_PFC_CAP, WGM_PC_CAP, WGM_CTC_CAP, WGM_FAST_CAP: begin
				top_value  = capture_value;
				cap_is_top = 1'b1;
			end
			WGM_NORMAL:            top_value = TOP_16;
			default:               top_value = TOP_16;
		endcase
	end

	// non-pwm modes: normal and both clear-on-match modes
	assign non_pwm = (waveform_mode_field == WGM_NORMAL) || (waveform_mode_field == WGM_CTC_A) ||
		(waveform_mode_field == WGM_CTC_CAP);

	// capture source: pin or the analog comparator
	assign cap_src   = capture_from_comparator ? analog_comp_out : capture_input_pin;

	// register write decodes
	assign wr_force  = cpu_wr && (cpu_addr == ADDR_FORCE);
	assign wr_cnt    = cpu_wr && (cpu_addr == ADDR_CNT);
	assign wr_cap    = cpu_wr && (cpu_addr == ADDR_CAP);
	assign wr_cmp[0] = cpu_wr && (cpu_addr == ADDR_CMPA);
	assign wr_cmp[1] = cpu_wr && (cpu_addr == ADDR_CMPB);

	// any high byte write lands in the shared latch
	assign wr_hi     = cpu_wr && (cpu_addr == ADDR_CNT + HI_OFS || cpu_addr == ADDR_CAP + HI_OFS ||
		cpu_addr == ADDR_CMPA + HI_OFS || cpu_addr == ADDR_CMPB + HI_OFS);
	// a low byte write completes the word from the latch
	assign wr_word   = {temp_hi, cpu_wdata};

	// per-channel output mode fields
	assign out_mode[0] = output_mode_field_a;
	assign out_mode[1] = output_mode_field_b;

	// per-channel compare and force logic
	for (genvar i = 0; i < 2; i++) begin : g_chan
		localparam int FBIT = (i == 0) ? FORCE_A_BIT : FORCE_B_BIT;
		assign match[i]  = evt.tick && !block_match && (counter_value == cmp_val[i]);
		assign forced[i] = wr_force && cpu_wdata[FBIT] && non_pwm;
		// real match and force strobe act alike on the output
		assign hit[i]    = match[i] || forced[i];
		// mode read at the strobe itself decides the effect
		always_comb begin
			case (out_mode[i])
				COM_TOGGLE: next_wave[i] = hit[i] ? ~wave[i] : wave[i];
				COM_CLEAR:  next_wave[i] = hit[i] ? 1'b0 : wave[i];
				COM_SET:    next_wave[i] = hit[i] ? 1'b1 : wave[i];
				default:    next_wave[i] = wave[i];
			endcase
		end
	end

	// top reached: the next tick wraps the counter to zero
	assign at_top = (counter_value == top_value);

	// counter next value; a cpu write wins over counting
	always_comb begin
		next_counter_value = counter_value;
		next_block_match   = block_match;
		if (wr_cnt) begin
			next_counter_value = wr_word;
			next_block_match   = 1'b1;
		end else if (evt.tick) begin
			next_block_match   = 1'b0;
			// a tick at top clears, even with the match blocked; a force never does
			next_counter_value = at_top ? WORD_RST : 16'(counter_value + 16'h0001);
		end
	end

	// capture register; a cpu write wins over a capture event
	always_comb begin
		next_capture_value = capture_value;
		if (wr_cap)
			next_capture_value = wr_word;
		else if (evt.cap_evt)
			next_capture_value = counter_value;
	end

	// compare registers load at once, no double buffering
	always_comb begin
		next_cmp_val[0] = wr_cmp[0] ? wr_word : cmp_val[0];
		next_cmp_val[1] = wr_cmp[1] ? wr_word : cmp_val[1];
	end

	// shared high-byte latch: low reads and high writes load it
	always_comb begin
		next_temp_hi = temp_hi;
		if (cpu_rd) begin
			case (cpu_addr)
				ADDR_CNT:  next_temp_hi = counter_value[15:8];
				ADDR_CAP:  next_temp_hi = capture_value[15:8];
				ADDR_CMPA: next_temp_hi = cmp_val[0][15:8];
				ADDR_CMPB: next_temp_hi = cmp_val[1][15:8];
				default:   next_temp_hi = temp_hi;
			endcase
		end
		if (wr_hi)
			next_temp_hi = cpu_wdata;
	end

	// read data, zero when no read and for unmapped bytes
	always_comb begin
		next_rdata = BYTE_RST;
		if (cpu_rd) begin
			case (cpu_addr)
				ADDR_FORCE: next_rdata = BYTE_RST;
				ADDR_CNT:   next_rdata = counter_value[7:0];
				ADDR_CAP:   next_rdata = capture_value[7:0];
				ADDR_CMPA:  next_rdata = cmp_val[0][7:0];
				ADDR_CMPB:  next_rdata = cmp_val[1][7:0];
				ADDR_CNT + HI_OFS, ADDR_CAP + HI_OFS, ADDR_CMPA + HI_OFS, ADDR_CMPB + HI_OFS:
					next_rdata = temp_hi;
				default:    next_rdata = BYTE_RST;
			endcase
		end
	end

	// event flag pulses; forced matches raise no flag
	always_comb begin
		next_cap_flag   = evt.cap_evt;
		next_cmp_flag_a = match[0];
		next_cmp_flag_b = match[1];
	end

	// counter and match block registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			counter_value <= WORD_RST;
			block_match   <= 1'b0;
		end else begin
			counter_value <= next_counter_value;
			block_match   <= next_block_match;
		end
	end

	// capture register
	always_ff @(posedge clk) begin
		if (!rst_b)
			capture_value <= WORD_RST;
		else
			capture_value <= next_capture_value;
	end

	// compare registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cmp_val[0] <= WORD_RST;
			cmp_val[1] <= WORD_RST;
		end else begin
			cmp_val[0] <= next_cmp_val[0];
			cmp_val[1] <= next_cmp_val[1];
		end
	end

	// shared high-byte latch register
	always_ff @(posedge clk) begin
		if (!rst_b)
			temp_hi <= BYTE_RST;
		else
			temp_hi <= next_temp_hi;
	end

	// read data register
	always_ff @(posedge clk) begin
		if (!rst_b)
			cpu_rdata <= BYTE_RST;
		else
			cpu_rdata <= next_rdata;
	end

	// waveform output registers
	always_ff @(posedge clk) begin
		if (!rst_b)
			wave <= 2'h0;
		else
			wave <= next_wave;
	end

	// event flag registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			capture_flag   <= 1'b0;
			compare_flag_a <= 1'b0;
			compare_flag_b <= 1'b0;
		end else begin
			capture_flag   <= next_cap_flag;
			compare_flag_a <= next_cmp_flag_a;
			compare_flag_b <= next_cmp_flag_b;
		end
	end

	// waveform pins straight from their registers
	assign waveform_out_a = wave[0];
	assign waveform_out_b = wave[1];
endmodule
